// ### verilog/tcc_pkg.sv
package tcc_pkg;

  // Widths of the stored fields and of the register word.
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CMD_W      = 8;
  localparam int unsigned COEF_W     = 8;
  localparam int unsigned TEMP_W     = 10;
  localparam int unsigned CUR_W      = 10;

  // Command codes that select each register.
  localparam logic [7:0] CMD_EXT_TEMP   = 8'h0d;
  localparam logic [7:0] CMD_SECOND_TC  = 8'h1b;
  localparam logic [7:0] CMD_FIRST_TC   = 8'h1a;

  // Field positions inside the 16-bit word.
  localparam int unsigned COEF_LSB      = 0;
  localparam int unsigned COEF_MSB      = 7;
  localparam int unsigned TEMP_LSB      = 0;
  localparam int unsigned TEMP_MSB      = 9;

  // Values after reset.
  localparam logic [7:0]  COEF_RESET    = 8'h00;
  localparam logic [9:0]  TEMP_RESET    = 10'h000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [9:0]  CUR_RESET     = 10'h000;

  // Scaling: first order is 2^-13 per degree, second order 2^-18 per degree squared.
  localparam int unsigned FIRST_SHIFT   = 13;
  localparam int unsigned SECOND_SHIFT  = 18;
  // Temperature codes per degree, as a power of two: half-degree steps give one.
  localparam int unsigned TEMP_STEP_SHIFT = 1;
  // Fractional bits of the gain factor; room for the squared half-degree difference.
  localparam int unsigned FRAC_BITS     = SECOND_SHIFT + 2 * TEMP_STEP_SHIFT;
  localparam int unsigned ALIGN_SHIFT   = FRAC_BITS - FIRST_SHIFT - TEMP_STEP_SHIFT;

  // Register bank state.
  typedef struct packed {
    logic [7:0]  first_coef;
    logic [7:0]  second_coef;
    logic [9:0]  ext_temp;
    logic [15:0] rd_data;
    logic        rd_ack;
    logic        wr_ack;
    logic        cmd_miss;
  } tcc_bank_t;

  // Compensation stage state.
  typedef struct packed {
    logic [9:0] comp_current;
    logic       clamped;
  } tcc_calc_t;

endpackage

// ### verilog/tcc_comp_calc.sv
`timescale 1ns/1ps
module tcc_comp_calc #(
  parameter int unsigned CW = 10
) (
  input  wire logic                        clk,            // Device clock.
  input  wire logic                        rst_b,          // Synchronous reset, active low.
  input  wire logic [tcc_pkg::COEF_W-1:0]  first_coef,     // Signed first-order coefficient.
  input  wire logic [tcc_pkg::COEF_W-1:0]  second_coef,    // Signed second-order coefficient.
  input  wire logic [tcc_pkg::TEMP_W-1:0]  ext_temp,       // Present temperature.
  input  wire logic [tcc_pkg::TEMP_W-1:0]  nom_temp,       // Nominal temperature.
  input  wire logic [CW-1:0]               nom_current,    // Nominal modulation current.
  output logic      [CW-1:0]               comp_current,   // Compensated current, registered.
  output logic                             clamped         // Result was limited, registered.
);
  import tcc_pkg::*;

  // The arithmetic is sized for a 10-bit current field.
  if (CW != 10) begin : g_bad_width
    $error("tcc_comp_calc supports CW of 10 only");
  end

  tcc_calc_t           s_q;
  tcc_calc_t           s_d;
  logic signed [10:0]  diff;
  logic signed [23:0]  lin;
  logic signed [21:0]  sq;
  logic signed [29:0]  quad;
  logic signed [31:0]  factor;
  logic signed [43:0]  prod;
  logic signed [43:0]  scaled;

  // Both temperatures share one encoding, so their difference counts half degrees.
  // The factor carries extra fractional bits that absorb the halving of each
  // temperature term, so the coefficient steps stay per whole degree.
  always_comb begin
    s_d    = s_q;
    diff   = $signed({1'b0, ext_temp}) - $signed({1'b0, nom_temp});
    lin    = (24'($signed(first_coef)) * 24'(diff)) <<< ALIGN_SHIFT;
    sq     = 22'(diff) * 22'(diff);
    quad   = 30'($signed(second_coef)) * 30'(sq);
    factor = (32'sd1 <<< FRAC_BITS) + 32'(lin) + 32'(quad);
    prod   = 44'($signed({1'b0, nom_current})) * 44'(factor);
    scaled = prod >>> FRAC_BITS;
    s_d.clamped = 1'b0;
    if (scaled < 44'sd0) begin
      s_d.comp_current = '0;
      s_d.clamped      = 1'b1;
    end else if (scaled > 44'sd1023) begin
      s_d.comp_current = '1;
      s_d.clamped      = 1'b1;
    end else begin
      s_d.comp_current = scaled[9:0];
    end
  end

  // Result register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{comp_current: CUR_RESET, clamped: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign comp_current = s_q.comp_current;
  assign clamped      = s_q.clamped;

endmodule

// ### verilog/tcc_coef_regs.sv
`timescale 1ns/1ps
// Operation
// - First-order coefficient: signed 8 bits in 7:0, upper byte reserved, resets zero.
// - One first-order step changes modulation current by 2^-13 per degree.
// - Second-order coefficient: signed 8 bits in 7:0, upper byte reserved, resets zero.
// - One second-order step changes current by 2^-18 per degree squared.
// - Command code 0x1B selects the second-order coefficient for reads and writes.
// - Command code 0x0D selects the external temperature register.
// - External temperature is unsigned 10 bits in 9:0, feeds compensation, resets zero.
// - Nominal temperature uses the same encoding as the external temperature.
module tcc_coef_regs (
  input  wire logic                         clk,              // Device clock, 10 MHz.
  input  wire logic                         rst_b,            // Synchronous reset, active low.
  input  wire logic [tcc_pkg::CMD_W-1:0]    cmd_code,         // Command code of the access.
  input  wire logic                         wr_stb,           // One-cycle write request.
  input  wire logic                         rd_stb,           // One-cycle read request.
  input  wire logic [tcc_pkg::WORD_W-1:0]   wr_data,          // Word to write.
  input  wire logic [tcc_pkg::TEMP_W-1:0]   nom_temp,         // Nominal temperature field.
  input  wire logic [tcc_pkg::CUR_W-1:0]    nominal_mod_current_field, // Nominal current.
  output logic      [tcc_pkg::WORD_W-1:0]   rd_data,          // Read word, held until next read.
  output logic                              rd_ack,           // One-cycle read answer.
  output logic                              wr_ack,           // One-cycle write answer.
  output logic                              cmd_miss,         // One-cycle unmapped-code flag.
  output logic      [tcc_pkg::COEF_W-1:0]   first_order_coef_field,  // Stored coefficient.
  output logic      [tcc_pkg::COEF_W-1:0]   second_order_coef_field, // Stored coefficient.
  output logic      [tcc_pkg::TEMP_W-1:0]   ext_temp_field,   // Stored temperature.
  output logic      [tcc_pkg::CUR_W-1:0]    comp_mod_current, // Compensated current.
  output logic                              comp_clamped      // Result was limited.
);
  import tcc_pkg::*;

  tcc_bank_t s_q;
  tcc_bank_t s_d;

  // Tells whether a command code selects one of this bank's registers.
  function automatic logic is_mapped(input logic [7:0] code);
    is_mapped = (code == CMD_FIRST_TC) || (code == CMD_SECOND_TC) || (code == CMD_EXT_TEMP);
  endfunction

  // Builds the 16-bit word a read returns; the unused upper bits are forced to zero.
  function automatic logic [15:0] read_word(input tcc_bank_t s, input logic [7:0] code);
    read_word = WORD_RESET;
    if (code == CMD_FIRST_TC) begin
      read_word[COEF_MSB:COEF_LSB] = s.first_coef;
    end else if (code == CMD_SECOND_TC) begin
      read_word[COEF_MSB:COEF_LSB] = s.second_coef;
    end else if (code == CMD_EXT_TEMP) begin
      read_word[TEMP_MSB:TEMP_LSB] = s.ext_temp;
    end
  endfunction

  // Access decode. A write stores only the field bits, so the reserved bits never
  // hold state. A read presents the word as stored before a write in the same cycle.
  always_comb begin
    s_d          = s_q;
    s_d.rd_ack   = 1'b0;
    s_d.wr_ack   = 1'b0;
    s_d.cmd_miss = 1'b0;
    if (wr_stb) begin
      s_d.wr_ack = 1'b1;
      if (cmd_code == CMD_FIRST_TC) begin
        s_d.first_coef = wr_data[COEF_MSB:COEF_LSB];
      end else if (cmd_code == CMD_SECOND_TC) begin
        s_d.second_coef = wr_data[COEF_MSB:COEF_LSB];
      end else if (cmd_code == CMD_EXT_TEMP) begin
        s_d.ext_temp = wr_data[TEMP_MSB:TEMP_LSB];
      end
    end
    if (rd_stb) begin
      s_d.rd_ack  = 1'b1;
      s_d.rd_data = read_word(s_q, cmd_code);
    end
    if ((wr_stb || rd_stb) && !is_mapped(cmd_code)) begin
      s_d.cmd_miss = 1'b1;
    end
  end

  // State register; every field clears at reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{first_coef:  COEF_RESET,
               second_coef: COEF_RESET,
               ext_temp:    TEMP_RESET,
               rd_data:     WORD_RESET,
               rd_ack:      1'b0,
               wr_ack:      1'b0,
               cmd_miss:    1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Compensation arithmetic works from the stored fields and the nominal inputs.
  tcc_comp_calc #(
    .CW           (CUR_W)
  ) u_calc (
    .clk          (clk),
    .rst_b        (rst_b),
    .first_coef   (s_q.first_coef),
    .second_coef  (s_q.second_coef),
    .ext_temp     (s_q.ext_temp),
    .nom_temp     (nom_temp),
    .nom_current  (nominal_mod_current_field),
    .comp_current (comp_mod_current),
    .clamped      (comp_clamped)
  );

  // Outputs come straight from the state register.
  assign rd_data                 = s_q.rd_data;
  assign rd_ack                  = s_q.rd_ack;
  assign wr_ack                  = s_q.wr_ack;
  assign cmd_miss                = s_q.cmd_miss;
  assign first_order_coef_field  = s_q.first_coef;
  assign second_order_coef_field = s_q.second_coef;
  assign ext_temp_field          = s_q.ext_temp;

endmodule

// ### verification/tcc_coef_regs_monitor.sv
`timescale 1ns/1ps
// Handshake and storage checks seen at the register bank ports.
module tcc_coef_regs_monitor
  import tcc_pkg::*;
(
  input wire logic        clk,                     // Device clock.
  input wire logic        rst_b,                   // Synchronous reset, active low.
  input wire logic [7:0]  cmd_code,                // Command code.
  input wire logic        wr_stb,                  // Write request.
  input wire logic        rd_stb,                  // Read request.
  input wire logic [15:0] wr_data,                 // Write word.
  input wire logic [15:0] rd_data,                 // Read word.
  input wire logic        rd_ack,                  // Read answer.
  input wire logic        wr_ack,                  // Write answer.
  input wire logic        cmd_miss,                // Unmapped code flag.
  input wire logic [7:0]  first_order_coef_field,  // Stored coefficient.
  input wire logic [7:0]  second_order_coef_field, // Stored coefficient.
  input wire logic [9:0]  ext_temp_field           // Stored temperature.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] wd_q;
  // Keeps the previous write word so stored fields can be compared with it.
  always_ff @(posedge clk) begin
    wd_q <= wr_data;
  end
  wire logic miss = cmd_code != CMD_EXT_TEMP && cmd_code != CMD_SECOND_TC &&
                    cmd_code != CMD_FIRST_TC;
  rd_ack_a: assert property (rd_stb |=> rd_ack) else $error("read not answered");
  ack_cause_a: assert property (wr_ack == $past(wr_stb) && rd_ack == $past(rd_stb))
    else $error("answer without matching request");
  sec_store_a: assert property (wr_stb && cmd_code == CMD_SECOND_TC |=>
    second_order_coef_field == wd_q[7:0]) else $error("second coefficient not stored");
  fst_store_a: assert property (wr_stb && cmd_code == CMD_FIRST_TC |=>
    first_order_coef_field == wd_q[7:0]) else $error("first coefficient not stored");
  temp_store_a: assert property (wr_stb && cmd_code == CMD_EXT_TEMP |=>
    ext_temp_field == wd_q[9:0]) else $error("temperature not stored");
  field_hold_a: assert property (!wr_stb || miss |=>
    $stable({first_order_coef_field, second_order_coef_field, ext_temp_field}))
    else $error("field changed without a write");
  sec_read_a: assert property (rd_stb && !wr_stb && cmd_code == CMD_SECOND_TC |=>
    rd_data == {8'h00, $past(second_order_coef_field)}) else $error("bad second read");
  temp_read_a: assert property (rd_stb && !wr_stb && cmd_code == CMD_EXT_TEMP |=>
    rd_data == {6'h00, $past(ext_temp_field)}) else $error("bad temperature read");
  miss_flag_a: assert property ((rd_stb || wr_stb) && miss |=>
    cmd_miss && (!$past(rd_stb) || rd_data == 16'h0000)) else $error("unmapped code");
  cover property (wr_stb && cmd_code == CMD_SECOND_TC);
  cover property (rd_stb && cmd_code == CMD_EXT_TEMP);
  cover property (rd_stb && miss);
endmodule
bind tcc_coef_regs tcc_coef_regs_monitor tcc_coef_regs_monitor_i (.clk, .rst_b, .cmd_code,
  .wr_stb, .rd_stb, .wr_data, .rd_data, .rd_ack, .wr_ack, .cmd_miss,
  .first_order_coef_field, .second_order_coef_field, .ext_temp_field);

// ### verification/tcc_host_model.sv
`timescale 1ns/1ps
// Serial host side: one pulse per access, answer taken while it stands.
module tcc_host_model (
  input  wire logic        clk,      // Device clock.
  output logic      [7:0]  cmd_code, // Command code.
  output logic             wr_stb,   // Write request.
  output logic             rd_stb,   // Read request.
  output logic      [15:0] wr_data,  // Write word.
  input  wire logic [15:0] rd_data,  // Read word.
  input  wire logic        rd_ack,   // Read answer.
  input  wire logic        wr_ack    // Write answer.
);
  // Idle bus at time zero.
  initial begin
    cmd_code = 8'h00;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    wr_data = 16'h0000;
  end
  // Half-degree steps with a Kelvin offset; the coefficients are scaled to match.
  function automatic logic [9:0] temp_code(input int deg_c);
    return 10'((deg_c + 273) * 2);
  endfunction
  // Released data shows the inverse word so a stale value cannot pass.
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] d,
                        output logic [15:0] q, output logic ack);
    @(posedge clk);
    cmd_code <= code;
    wr_data <= d;
    wr_stb <= wr;
    rd_stb <= !wr;
    @(posedge clk);
    wr_stb <= 1'h0;
    rd_stb <= 1'h0;
    wr_data <= ~d;
    #1;
    q = rd_data;
    ack = wr ? wr_ack : rd_ack;
  endtask
endmodule

// ### verification/test_tcc_coef_regs.sv
`timescale 1ns/1ps
// Self-checking bench for the coefficient register bank.
module test_tcc_coef_regs;
  import tcc_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, wr_stb, rd_stb, rd_ack, wr_ack, cmd_miss, clamped, ak;
  logic [7:0] cmd_code, fst, sec;
  logic [9:0] nom_temp = 10'h254, nom_cur = 10'h200, temp, cur;
  logic [15:0] wr_data, rd_data, q;
  int bad_count = 0, n_tests = 0;
  tcc_host_model tcc_host_model_i (.clk, .cmd_code, .wr_stb, .rd_stb, .wr_data,
    .rd_data, .rd_ack, .wr_ack);
  tcc_coef_regs tcc_coef_regs_i (.clk, .rst_b, .cmd_code, .wr_stb, .rd_stb, .wr_data,
    .nom_temp, .nominal_mod_current_field(nom_cur), .rd_data, .rd_ack, .wr_ack, .cmd_miss,
    .first_order_coef_field(fst), .second_order_coef_field(sec), .ext_temp_field(temp),
    .comp_mod_current(cur), .comp_clamped(clamped));
  // Clock, 100 ns period.
  always #50 clk = ~clk;
  task automatic check(input logic [15:0] e, input logic [15:0] a);
    n_tests++;
    if (a !== e) begin
      bad_count++;
      $display("Error at %0t: expected %h, got %h", $time, e, a);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    tcc_host_model_i.access(w, c, d, q, ak);
    check(16'h0001, {15'h0, ak});
  endtask
  task automatic t_reset();
    acc(1'h0, CMD_FIRST_TC, 16'h0);
    check(16'h0000, q);
    check(16'h0000, {fst, sec});
    check(16'h0000, {6'h00, temp});
  endtask
  task automatic t_second();
    acc(1'h1, CMD_SECOND_TC, 16'hff80);
    acc(1'h0, CMD_SECOND_TC, 16'h0);
    check(16'h0080, q);
  endtask
  task automatic t_first();
    acc(1'h1, CMD_FIRST_TC, 16'h7f7f);
    acc(1'h0, CMD_FIRST_TC, 16'h0);
    check(16'h007f, q);
  endtask
  task automatic t_miss();
    acc(1'h1, 8'h00, 16'h1234);
    check(16'h1, {15'h0, cmd_miss});
    acc(1'h0, 8'h00, 16'h0);
    check(16'h0, q);
    check(16'h7f80, {fst, sec});
  endtask
  task automatic t_temp();
    acc(1'h1, CMD_EXT_TEMP, 16'hffff);
    acc(1'h0, CMD_EXT_TEMP, 16'h0);
    check(16'h03ff, q);
  endtask
  // Temperature 32 degrees above nominal with maximum first order: the minimum second
  // order nearly cancels it, without it the current rises, and far below it clamps.
  task automatic t_comp();
    acc(1'h1, CMD_FIRST_TC, 16'h007f);
    acc(1'h1, CMD_SECOND_TC, 16'h0080);
    acc(1'h1, CMD_EXT_TEMP, {6'h0, tcc_host_model_i.temp_code(57)});
    repeat (3) @(posedge clk);
    #1;
    check(16'h03fc, {5'h0, cur, clamped});
    acc(1'h1, CMD_SECOND_TC, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    check(16'h05fc, {5'h0, cur, clamped});
    acc(1'h1, CMD_EXT_TEMP, {6'h0, tcc_host_model_i.temp_code(-273)});
    repeat (3) @(posedge clk);
    #1;
    check(16'h0001, {5'h0, cur, clamped});
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_second();
    t_first();
    t_miss();
    t_temp();
    t_comp();
    test_done();
  end
  // Watchdog well beyond the expected run of about fifty cycles.
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
